/* include/nir_pkg.sv */
package nir_pkg;
  // register byte offsets
  localparam logic [11:0] NIR_OFF_MODE   = 12'h000;
  localparam logic [11:0] NIR_OFF_LIP    = 12'h004;
  localparam logic [11:0] NIR_OFF_MASK   = 12'h008;
  localparam logic [11:0] NIR_OFF_PORT   = 12'h00C;
  localparam logic [11:0] NIR_OFF_STAT   = 12'h010;
  localparam logic [11:0] NIR_OFF_TBL    = 12'h100;
  localparam int          NIR_TBL_STRIDE = 8;
  localparam int          NIR_TBL_IP_OFS = 4;
  // mode word fields and table entry valid bit
  localparam int NIR_MODE_HOSTNUM = 0;
  localparam int NIR_MODE_CONV    = 2;
  localparam int NIR_MODE_DEFPORT = 4;
  localparam int NIR_TBL_VLD      = 31;
  // status word fields
  localparam int NIR_ST_RES_ERR   = 0;
  localparam int NIR_ST_PORT_DROP = 1;
  localparam int NIR_ST_LEN_DROP  = 2;
  localparam int NIR_ST_GW_DROP   = 3;
  localparam int NIR_ST_BC_DROP   = 4;
  localparam int NIR_ST_NODE_ERR  = 5;
  localparam int NIR_ST_NFLAGS    = 6;
  localparam int NIR_ST_PORT_LSB  = 16;
  // reset values
  localparam logic [4:0]  NIR_MODE_RST = 5'h00;
  localparam logic [31:0] NIR_IP_RST   = 32'h0000_0000;
  localparam logic [15:0] NIR_PORT_RST = 16'h0000;
  // protocol figures
  localparam logic [15:0] NIR_DEF_PORT    = 16'h2580;
  localparam logic [15:0] NIR_MAX_MSG     = 16'h07D2;
  localparam logic [15:0] NIR_GW_WIDE_MAX = 16'h0800;
  localparam logic [15:0] NIR_GW_NARR_MAX = 16'h0228;
  localparam logic [7:0]  NIR_NODE_MIN    = 8'h01;
  localparam logic [7:0]  NIR_NODE_MAX    = 8'h7E;
  localparam logic [1:0]  NIR_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  NIR_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    NIR_CONV_AUTO     = 2'b00,
    NIR_CONV_AUTO_ALT = 2'b01,
    NIR_CONV_TABLE    = 2'b10,
    NIR_CONV_COMBINED = 2'b11
  } nir_conv_e;

  typedef enum logic [1:0] {
    NIR_NET_ETH    = 2'b00,
    NIR_NET_WIDE   = 2'b01,
    NIR_NET_NARR_A = 2'b10,
    NIR_NET_NARR_B = 2'b11
  } nir_net_e;
endpackage

/* design/nir_top.sv */
// Functional notes
// [RULE1]: auto address is (ip AND mask) plus node
// [RULE2]: node numbers must be 1 to 126
// [RULE3]: table mode sends to matching entry's address
// [RULE4]: combined mode: table first, auto on miss
// [RULE5]: method comes from software mode setting
// [RULE6]: mode bits 3:2 select method; 1x uses table
// [RULE7]: forward message bytes only, headers dropped
// [RULE8]: responses resolve node to address before sending
// [RULE9]: port 9600 by default, configurable
// [RULE10]: datagrams to configured port are messages
// [RULE11]: send with configured port as source and destination
// [RULE12]: drop messages from other source ports
// [RULE13]: configured port zero means 9600
// [RULE14]: messages over 2002 bytes are refused
// [RULE15]: gateway limits 2 Kbytes or 552 bytes
// [RULE16]: gateway passes command traffic, never socket traffic
// [RULE17]: routed segments share one network address
// [RULE18]: routed reach needs router tables per unit
// [RULE19]: no broadcast across an IP router
// [RULE20]: table-only miss drops and flags error
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module nir_top
  import nir_pkg::*;
#(
  parameter int TBL_DEPTH = 8
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // received datagram payload, udp fields valid on the first beat
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_first,
  input  wire logic        rx_last,
  input  wire logic [15:0] rx_src_port,
  input  wire logic [15:0] rx_dst_port,
  input  wire logic [15:0] rx_len,
  // stripped protocol message out
  output logic             msg_valid,
  input  wire logic        msg_ready,
  output logic [7:0]       msg_data,
  output logic             msg_last,
  // outgoing resolve request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_node,
  input  wire logic [15:0] req_len,
  input  wire logic        req_gateway,
  input  wire logic [1:0]  req_net,
  input  wire logic        req_socket,
  input  wire logic        req_bcast,
  input  wire logic        req_routed,
  // resolve answer
  output logic             rsp_valid,
  output logic             rsp_drop,
  output logic [31:0]      rsp_ip,
  output logic [15:0]      rsp_src_port,
  output logic [15:0]      rsp_dst_port
);
  localparam int IDX_W = $clog2(TBL_DEPTH);

  logic [4:0]  mode_q;
  logic [31:0] lip_q;
  logic [31:0] mask_q;
  logic [15:0] port_q;
  logic [NIR_ST_NFLAGS-1:0] stat_q;
  logic [6:0]  tbl_node_q [TBL_DEPTH];
  logic        tbl_vld_q  [TBL_DEPTH];
  logic [31:0] tbl_ip_q   [TBL_DEPTH];

  logic [11:0] awaddr_q;
  logic        aw_hold_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_hold_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- bus slave ----------------
  logic do_wr;
  logic [31:0] wr_val_mode;
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_wr         = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_val_mode   = merge({27'h0, mode_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_hold_q <= 1'b0;
    end
  end

  logic wr_tbl;
  logic [IDX_W-1:0] wr_idx;
  assign wr_tbl = (awaddr_q >= NIR_OFF_TBL) &&
                  (awaddr_q < NIR_OFF_TBL + 12'(TBL_DEPTH * NIR_TBL_STRIDE));
  assign wr_idx = IDX_W'((awaddr_q - NIR_OFF_TBL) >> 3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= NIR_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_tbl || awaddr_q inside {NIR_OFF_MODE, NIR_OFF_LIP, NIR_OFF_MASK,
                   NIR_OFF_PORT, NIR_OFF_STAT}) ? NIR_RESP_OKAY : NIR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // configuration: method and port are software choices [RULE5]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= NIR_MODE_RST;
      lip_q  <= NIR_IP_RST;
      mask_q <= NIR_IP_RST;
      port_q <= NIR_PORT_RST;
    end else if (do_wr) begin
      unique case (awaddr_q)
        NIR_OFF_MODE: mode_q <= wr_val_mode[4:0];
        NIR_OFF_LIP:  lip_q  <= merge(lip_q, wdata_q, wstrb_q);
        NIR_OFF_MASK: mask_q <= merge(mask_q, wdata_q, wstrb_q);
        NIR_OFF_PORT: port_q <= 16'(merge({16'h0, port_q}, wdata_q, wstrb_q)); // [RULE9]
        default: ;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < TBL_DEPTH; i++) begin : g_tbl
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tbl_vld_q[i]  <= 1'b0;
          tbl_node_q[i] <= 7'h00;
          tbl_ip_q[i]   <= NIR_IP_RST;
        end else if (do_wr && wr_tbl && wr_idx == IDX_W'(i)) begin
          if (awaddr_q[2]) begin
            tbl_ip_q[i] <= merge(tbl_ip_q[i], wdata_q, wstrb_q);
          end else begin
            if (wstrb_q[0]) tbl_node_q[i] <= wdata_q[6:0];
            if (wstrb_q[3]) tbl_vld_q[i]  <= wdata_q[NIR_TBL_VLD];
          end
        end
      end
    end
  endgenerate

  // effective port: zero or the default bit selects 9600
  logic [15:0] eff_port;
  assign eff_port = (mode_q[NIR_MODE_DEFPORT] || port_q == 16'h0000) ?
                    NIR_DEF_PORT : port_q; // [RULE9] [RULE13]

  logic [31:0] rd_mux;
  logic [11:0] rd_ofs;
  logic        rd_ok;
  always_comb begin
    rd_ofs = s_axi_araddr - NIR_OFF_TBL;
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr == NIR_OFF_MODE) begin
      rd_mux = {27'h0, mode_q};
    end else if (s_axi_araddr == NIR_OFF_LIP) begin
      rd_mux = lip_q;
    end else if (s_axi_araddr == NIR_OFF_MASK) begin
      rd_mux = mask_q;
    end else if (s_axi_araddr == NIR_OFF_PORT) begin
      rd_mux = {16'h0, port_q};
    end else if (s_axi_araddr == NIR_OFF_STAT) begin
      rd_mux = {eff_port, 10'h0, stat_q};
    end else if (s_axi_araddr >= NIR_OFF_TBL &&
                 rd_ofs < 12'(TBL_DEPTH * NIR_TBL_STRIDE) && s_axi_araddr[1:0] == 2'b00) begin
      rd_mux = rd_ofs[2] ? tbl_ip_q[IDX_W'(rd_ofs >> 3)] :
               {tbl_vld_q[IDX_W'(rd_ofs >> 3)], 24'h0, tbl_node_q[IDX_W'(rd_ofs >> 3)]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= NIR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? NIR_RESP_OKAY : NIR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- receive path ----------------
  logic msg_valid_q;
  logic [7:0] msg_data_q;
  logic msg_last_q;
  logic keep_q;
  logic rx_fire;
  logic port_ok;
  logic len_ok;
  logic beat_keep;
  assign rx_ready  = !msg_valid_q || msg_ready;
  assign rx_fire   = rx_valid && rx_ready;
  assign port_ok   = (rx_dst_port == eff_port) && (rx_src_port == eff_port); // [RULE10] [RULE12]
  assign len_ok    = rx_len <= NIR_MAX_MSG; // [RULE14]
  assign beat_keep = rx_first ? (port_ok && len_ok) : keep_q;
  assign msg_valid = msg_valid_q;
  assign msg_data  = msg_data_q;
  assign msg_last  = msg_last_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keep_q <= 1'b0;
    end else if (rx_fire && rx_first) begin
      keep_q <= port_ok && len_ok;
    end
  end

  // only payload bytes are loaded; headers never reach this stage [RULE7]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg_valid_q <= 1'b0;
      msg_data_q  <= 8'h00;
      msg_last_q  <= 1'b0;
    end else if (rx_fire && beat_keep) begin
      msg_valid_q <= 1'b1;
      msg_data_q  <= rx_data;
      msg_last_q  <= rx_last;
    end else if (msg_ready) begin
      msg_valid_q <= 1'b0;
    end
  end

  // ---------------- resolve path ----------------
  nir_conv_e conv;
  logic [31:0] auto_ip;
  logic [TBL_DEPTH-1:0] hit;
  logic [31:0] tbl_ip;
  logic any_hit;
  logic node_bad;
  logic gw_bad;
  logic len_bad;
  logic bc_bad;
  logic miss_bad;
  logic req_fire;
  logic [15:0] gw_max;

  assign conv    = nir_conv_e'(mode_q[NIR_MODE_CONV +: 2]); // [RULE6]
  assign auto_ip = (lip_q & mask_q) + {24'h0, req_node}; // [RULE1]
  assign any_hit = |hit;
  assign req_ready = 1'b1;
  assign req_fire  = req_valid;

  generate
    for (genvar i = 0; i < TBL_DEPTH; i++) begin : g_hit
      assign hit[i] = tbl_vld_q[i] && ({1'b0, tbl_node_q[i]} == req_node); // [RULE3]
    end
  endgenerate

  // lowest matching entry wins when software loads duplicates
  always_comb begin
    tbl_ip = 32'h0000_0000;
    for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
      if (hit[i]) tbl_ip = tbl_ip_q[i];
    end
  end

  assign gw_max   = (req_net == NIR_NET_WIDE) ? NIR_GW_WIDE_MAX : NIR_GW_NARR_MAX;
  assign node_bad = req_node < NIR_NODE_MIN || req_node > NIR_NODE_MAX; // [RULE2]
  assign gw_bad   = req_gateway && (req_socket || // [RULE16]
                    (req_net != NIR_NET_ETH && req_len > gw_max)); // [RULE15]
  assign len_bad  = req_len > NIR_MAX_MSG; // [RULE14]
  assign bc_bad   = req_bcast && req_routed; // [RULE19]
  assign miss_bad = conv == NIR_CONV_TABLE && !any_hit; // [RULE20]

  logic rsp_valid_q;
  logic rsp_drop_q;
  logic [31:0] rsp_ip_q;
  logic [15:0] rsp_port_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid_q <= 1'b0;
      rsp_drop_q  <= 1'b0;
      rsp_ip_q    <= 32'h0000_0000;
      rsp_port_q  <= NIR_DEF_PORT;
    end else begin
      rsp_valid_q <= req_fire;
      if (req_fire) begin
        rsp_drop_q <= node_bad || gw_bad || len_bad || bc_bad || miss_bad;
        rsp_port_q <= eff_port; // [RULE11]
        unique case (conv)
          NIR_CONV_TABLE:    rsp_ip_q <= any_hit ? tbl_ip : 32'h0000_0000; // [RULE3]
          NIR_CONV_COMBINED: rsp_ip_q <= any_hit ? tbl_ip : auto_ip; // [RULE4]
          NIR_CONV_AUTO,
          NIR_CONV_AUTO_ALT: rsp_ip_q <= auto_ip; // [RULE1] [RULE8]
        endcase
      end
    end
  end
  assign rsp_valid    = rsp_valid_q;
  assign rsp_drop     = rsp_drop_q;
  assign rsp_ip       = rsp_ip_q;
  assign rsp_src_port = rsp_port_q;
  assign rsp_dst_port = rsp_port_q;

  // sticky status, write one to clear; a same-cycle event beats the clear
  logic [NIR_ST_NFLAGS-1:0] st_set;
  logic [NIR_ST_NFLAGS-1:0] st_clr;
  logic rx_drop;
  assign rx_drop = rx_fire && rx_first;
  always_comb begin
    st_set = '0;
    st_set[NIR_ST_RES_ERR]   = req_fire && miss_bad; // [RULE20]
    st_set[NIR_ST_PORT_DROP] = rx_drop && !port_ok; // [RULE12]
    st_set[NIR_ST_LEN_DROP]  = (rx_drop && !len_ok) || (req_fire && len_bad);
    st_set[NIR_ST_GW_DROP]   = req_fire && gw_bad;
    st_set[NIR_ST_BC_DROP]   = req_fire && bc_bad;
    st_set[NIR_ST_NODE_ERR]  = req_fire && node_bad;
    st_clr = (do_wr && awaddr_q == NIR_OFF_STAT && wstrb_q[0]) ?
             wdata_q[NIR_ST_NFLAGS-1:0] : '0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~st_clr) | st_set;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_req(nir_conv_e m);
    req_fire && conv == m;
  endsequence

  property p_auto_ip;
    s_req(NIR_CONV_AUTO) |=> rsp_valid && rsp_ip == $past(lip_q & mask_q) + $past(req_node);
  endproperty
  a_auto_ip: assert property (p_auto_ip) else $error("auto address wrong"); // [RULE1]

  property p_node_range;
    req_fire && req_node == 8'h7F |=> rsp_drop ##1 stat_q[NIR_ST_NODE_ERR];
  endproperty
  a_node_range: assert property (p_node_range) else $error("node 127 not refused"); // [RULE2]

  property p_table;
    s_req(NIR_CONV_TABLE) ##0 hit[0] |=> rsp_ip == $past(tbl_ip_q[0]);
  endproperty
  a_table: assert property (p_table) else $error("table address not used"); // [RULE3]

  property p_comb_fallback;
    s_req(NIR_CONV_COMBINED) ##0 !any_hit |=> rsp_ip == $past(auto_ip) && !$past(miss_bad);
  endproperty
  a_comb_fallback: assert property (p_comb_fallback) else $error("no fallback"); // [RULE4]

  property p_port_default;
    req_fire && port_q == 16'h0000 |=> rsp_src_port == NIR_DEF_PORT;
  endproperty
  a_port_default: assert property (p_port_default) else $error("zero port used"); // [RULE13]

  property p_tx_ports;
    req_fire |=> rsp_src_port == $past(eff_port) && rsp_dst_port == rsp_src_port;
  endproperty
  a_tx_ports: assert property (p_tx_ports) else $error("ports differ"); // [RULE11]

  property p_rx_port;
    rx_fire && rx_first && rx_src_port != eff_port
      |=> msg_valid_q == $past(msg_valid_q && !msg_ready) ##0 stat_q[NIR_ST_PORT_DROP];
  endproperty
  a_rx_port: assert property (p_rx_port) else $error("foreign port forwarded"); // [RULE12]

  property p_miss;
    s_req(NIR_CONV_TABLE) ##0 !any_hit |=> rsp_valid && rsp_drop ##1 stat_q[NIR_ST_RES_ERR];
  endproperty
  a_miss: assert property (p_miss) else $error("table miss not flagged"); // [RULE20]

  property p_gw_socket;
    req_fire && req_gateway && req_socket |=> rsp_drop;
  endproperty
  a_gw_socket: assert property (p_gw_socket) else $error("socket via gateway"); // [RULE16]

  property p_bcast;
    req_fire && req_bcast && req_routed |=> rsp_drop [*1] ##1 stat_q[NIR_ST_BC_DROP];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast crossed router"); // [RULE19]
endmodule
`default_nettype wire

/* verification/nir_remote_host.sv */
`timescale 1ns/10ps
`default_nettype none
module nir_remote_host (
  // clock
  input  wire logic        aclk,
  // datagrams toward the unit
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_first,
  output logic             rx_last,
  output logic [15:0]      rx_src_port,
  output logic [15:0]      rx_dst_port,
  output logic [15:0]      rx_len,
  // stripped messages back
  input  wire logic        msg_valid,
  output logic             msg_ready,
  input  wire logic [7:0]  msg_data,
  input  wire logic        msg_last
);
  logic       slow;
  logic [8:0] got[$];

  initial begin
    slow = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_first = 1'b0;
    rx_last = 1'b0;
    rx_src_port = 16'h0000;
    rx_dst_port = 16'h0000;
    rx_len = 16'h0000;
    msg_ready = 1'b1;
  end

  // a slow host stalls every other cycle, so the output register must hold
  always @(posedge aclk) msg_ready <= slow ? ~msg_ready : 1'b1;
  always @(posedge aclk) if (msg_valid && msg_ready) got.push_back({msg_last, msg_data});

  // a peer shares one port for source and destination; callers break it on purpose
  task automatic send(input logic [15:0] sp, dp, ln, input int nb, input logic [7:0] b0);
    int   i;
    int   n;
    logic hs;
    for (i = 0; i < nb; i++) begin
      rx_valid <= 1'b1;
      rx_data <= b0 + 8'(i);
      rx_first <= (i == 0);
      rx_last <= (i == nb - 1);
      rx_src_port <= sp;
      rx_dst_port <= dp;
      rx_len <= ln;
      hs = 1'b0;
      for (n = 0; n < 200 && !hs; n++) begin
        @(negedge aclk);
        hs = rx_ready;
        @(posedge aclk);
      end
    end
    // released lines must not keep showing the last byte
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_src_port <= ~rx_src_port;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* verification/node_to_ip_resolver_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module node_to_ip_resolver_bench
  import nir_pkg::*;
();
  typedef struct packed {
    logic [1:0]  conv;
    logic [7:0]  node;
    logic [15:0] len;
    logic        gw;
    logic [1:0]  net;
    logic        sock, bc, rt, drop;
    logic [31:0] ip;
  } nir_row_s;

  localparam int NR = 22;
  localparam nir_row_s ROWS [NR] = '{
    '{2'b00, 8'h4B, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b01, 8'h4B, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b10, 8'h0B, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'h961F0253},
    '{2'b10, 8'h4B, 16'h000A, 0, 2'b00, 0, 0, 0, 1, 32'h00000000},
    '{2'b11, 8'h0B, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'h961F0253},
    '{2'b11, 8'h4B, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b00, 8'h01, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'hC0A80A01},
    '{2'b00, 8'h7E, 16'h000A, 0, 2'b00, 0, 0, 0, 0, 32'hC0A80A7E},
    '{2'b00, 8'h00, 16'h000A, 0, 2'b00, 0, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h7F, 16'h000A, 0, 2'b00, 0, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h07D2, 0, 2'b00, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b00, 8'h4B, 16'h07D3, 0, 2'b00, 0, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h0800, 1, 2'b01, 0, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h07D0, 1, 2'b01, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b00, 8'h4B, 16'h0228, 1, 2'b10, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b00, 8'h4B, 16'h0229, 1, 2'b10, 0, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h0229, 1, 2'b11, 0, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h07D0, 1, 2'b00, 0, 0, 0, 0, 32'hC0A80A4B},
    '{2'b00, 8'h4B, 16'h000A, 1, 2'b00, 1, 0, 0, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h000A, 0, 2'b00, 1, 0, 0, 0, 32'hC0A80A4B},
    '{2'b00, 8'h4B, 16'h000A, 0, 2'b00, 0, 1, 1, 1, 32'h00000000},
    '{2'b00, 8'h4B, 16'h000A, 0, 2'b00, 0, 1, 0, 0, 32'hC0A80A4B}
  };
  localparam logic [8:0] EXP_RX [6] = '{9'h0A0, 9'h0A1, 9'h0A2, 9'h1A3, 9'h0B0, 9'h1B1};

  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, rx_valid, rx_ready, rx_first, rx_last, msg_valid, msg_ready;
  logic        msg_last, req_valid, req_ready, req_gateway, req_socket, req_bcast, req_routed;
  logic        rsp_valid, rsp_drop;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rsp_ip, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, req_net, r;
  logic [7:0]  rx_data, msg_data, req_node;
  logic [15:0] rx_src_port, rx_dst_port, rx_len, req_len, rsp_src_port, rsp_dst_port, eport;
  int          bad_count, samples_checked, i;

  always #2.5 aclk = ~aclk;

  nir_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_first(rx_first),
    .rx_last(rx_last), .rx_src_port(rx_src_port), .rx_dst_port(rx_dst_port), .rx_len(rx_len),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_data(msg_data), .msg_last(msg_last),
    .req_valid(req_valid), .req_ready(req_ready), .req_node(req_node), .req_len(req_len),
    .req_gateway(req_gateway), .req_net(req_net), .req_socket(req_socket),
    .req_bcast(req_bcast), .req_routed(req_routed), .rsp_valid(rsp_valid),
    .rsp_drop(rsp_drop), .rsp_ip(rsp_ip), .rsp_src_port(rsp_src_port),
    .rsp_dst_port(rsp_dst_port)
  );

  nir_remote_host rh_u (
    .aclk(aclk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_first(rx_first), .rx_last(rx_last), .rx_src_port(rx_src_port),
    .rx_dst_port(rx_dst_port), .rx_len(rx_len), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_data(msg_data), .msg_last(msg_last)
  );

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic timed_out();
    bad_count++;
    stop_test();
  endtask

  // ready is sampled mid-cycle: it only moves after a rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    int   n;
    logic ad, wd, bv;
    ad = 1'b0;
    wd = 1'b0;
    bv = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !bv; n++) begin
      @(negedge aclk);
      ad |= s_axi_awvalid && s_axi_awready;
      wd |= s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    if (!bv) timed_out();
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int   n;
    logic ar, rv;
    ar = 1'b0;
    rv = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !rv; n++) begin
      @(negedge aclk);
      ar |= s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    if (!rv) timed_out();
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    axi_rd(a);
    check(d, e);
  endtask

  task automatic do_req(input nir_row_s w);
    req_valid <= 1'b1;
    req_node <= w.node;
    req_len <= w.len;
    req_gateway <= w.gw;
    req_net <= w.net;
    req_socket <= w.sock;
    req_bcast <= w.bc;
    req_routed <= w.rt;
    @(posedge aclk);
    req_valid <= 1'b0;
    req_node <= ~w.node;
    @(negedge aclk);
    check({req_ready, rsp_valid}, 2'b11);
    check(rsp_drop, w.drop);
    if (!w.drop || w.conv == 2'b10) check(rsp_ip, w.ip);
    check({rsp_src_port, rsp_dst_port}, {eport, eport});
    @(negedge aclk);
    check(rsp_valid, 1'b0);
    @(posedge aclk);
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    timed_out();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    {req_valid, req_gateway, req_socket, req_bcast, req_routed, req_net} = 7'h00;
    {req_node, req_len} = 24'h0;
    bad_count = 0;
    samples_checked = 0;
    eport = NIR_DEF_PORT;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(NIR_OFF_MODE, 32'h0);
    rd_chk(NIR_OFF_STAT, {NIR_DEF_PORT, 16'h0});
    rd_chk(12'hFFC, 32'h0);
    check(r, NIR_RESP_SLVERR);
    axi_wr(12'hFFC, 32'h0);
    check(r, NIR_RESP_SLVERR);
    axi_wr(NIR_OFF_LIP, 32'hC0A80A05);
    axi_wr(NIR_OFF_MASK, 32'hFFFFFF00);
    axi_wr(NIR_OFF_PORT, 32'h1234);
    // a second entry for the same node checks that the lowest index wins
    axi_wr(NIR_OFF_TBL, 32'h8000000B);
    axi_wr(NIR_OFF_TBL + 12'h004, 32'h961F0253);
    axi_wr(NIR_OFF_TBL + 12'h008, 32'h8000000B);
    axi_wr(NIR_OFF_TBL + 12'h00C, 32'h01010101);
    eport = 16'h1234;
    for (i = 0; i < NR; i++) begin
      axi_wr(NIR_OFF_MODE, {28'h0, ROWS[i].conv, 2'b00});
      do_req(ROWS[i]);
    end
    axi_rd(NIR_OFF_STAT);
    check({d[31:16], d[5:3], d[0]}, {16'h1234, 4'hF});
    axi_wr(NIR_OFF_STAT, 32'h3F);
    check(r, NIR_RESP_OKAY);
    rd_chk(NIR_OFF_STAT, {16'h1234, 16'h0});
    rh_u.slow = 1'b1;
    rh_u.send(16'h1234, 16'h1234, 16'h0004, 4, 8'hA0);
    rh_u.send(16'h2580, 16'h1234, 16'h0003, 3, 8'hC0);
    rh_u.send(16'h1234, 16'h2580, 16'h0003, 3, 8'hC4);
    rh_u.send(16'h1234, 16'h1234, 16'h07D3, 3, 8'hC8);
    rh_u.send(16'h1234, 16'h1234, 16'h07D2, 2, 8'hB0);
    repeat (20) @(posedge aclk);
    check(rh_u.got.size(), 6);
    for (i = 0; i < 6 && i < rh_u.got.size(); i++) check(rh_u.got[i], EXP_RX[i]);
    axi_rd(NIR_OFF_STAT);
    check(d[2:1], 2'b11);
    axi_wr(NIR_OFF_PORT, 32'h0);
    eport = NIR_DEF_PORT;
    do_req(ROWS[0]);
    axi_wr(NIR_OFF_PORT, 32'h1234);
    axi_wr(NIR_OFF_MODE, 32'h10);
    do_req(ROWS[0]);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({rsp_ip, rsp_src_port, rsp_dst_port}, {32'h0, NIR_DEF_PORT, NIR_DEF_PORT});
    @(posedge aclk);
    rd_chk(NIR_OFF_PORT, 32'h0);
    rd_chk(NIR_OFF_LIP, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
